// ===== logic/bls_ctrl.sv
// Host-side controller driving an asynchronous 16-bit byte-lane static RAM.
// Assumes a user port with req/ack handshake and RAM pins sampled on sys_clk.
// Functional notes
// - Address changes only while write enable or chip select is high.
// - Recovery counts from first rising select or write enable.
// - Host must not drive opposite data while memory outputs are on.
// - Consecutive reads at least 50 ns apart.
// - Each write cycle at least 50 ns long.
// - Write pulse low at least 40 ns.
// - Address valid at least 45 ns before write end.
// - Write data valid at least 20 ns before write end.
// - In the half-size option the top address bit stays low.
`timescale 1ns/1ps
module bls_ctrl (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic half_size_in,
    input wire logic req_in,
    input wire logic req_write_in,
    input wire logic [1:0] req_lanes_in,
    input wire logic [bls_pkg::BLS_ADDR_W-1:0] req_addr_in,
    input wire logic [bls_pkg::BLS_DATA_W-1:0] req_wdata_in,
    output logic req_ready_out,
    output logic rd_valid_out,
    output logic [bls_pkg::BLS_DATA_W-1:0] rd_data_out,
    output logic [bls_pkg::BLS_ADDR_W-1:0] mem_addr_out,
    output logic chip_select_n_out,
    output logic upper_byte_n_out,
    output logic lower_byte_n_out,
    output logic output_enable_n_out,
    output logic write_enable_n_out,
    input wire logic [bls_pkg::BLS_DATA_W-1:0] mem_data_in,
    output logic [bls_pkg::BLS_DATA_W-1:0] mem_data_out,
    output logic [bls_pkg::BLS_DATA_W-1:0] mem_data_oe_out
);
    import bls_pkg::*;

    bls_state_t state_q;
    logic [2:0] cnt_q;
    logic take;
    logic [1:0] lanes_q;

    // Per-bit mask of the selected byte lanes, upper lane in bit 1
    function automatic logic [BLS_DATA_W-1:0] lane_bits(
        input logic [1:0] lanes
    );
        return {{8{lanes[1]}}, {8{lanes[0]}}};
    endfunction

    // ------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------
    assign req_ready_out = (state_q == BLS_IDLE);
    // An empty lane mask is never taken; the requester keeps waiting
    assign take = req_ready_out && req_in && (req_lanes_in != 2'h0);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Each access ends in a recovery cycle with all strobes high, so
    // back-to-back cycles start at least four clocks (100 ns) apart.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= BLS_IDLE;
            cnt_q <= 3'h0;
        end else begin
            unique case (state_q)
                BLS_IDLE: begin
                    if (take) begin
                        state_q <= req_write_in ? BLS_WRITE : BLS_READ;
                        cnt_q <= req_write_in ? BLS_WR_PULSE : BLS_RD_WAIT;
                    end
                end
                BLS_READ: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        state_q <= BLS_RECOV;
                        cnt_q <= BLS_WR_RECOV;
                    end
                end
                BLS_WRITE: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        state_q <= BLS_RECOV;
                        cnt_q <= BLS_WR_RECOV;
                    end
                end
                BLS_RECOV: begin
                    cnt_q <= cnt_q - 3'h1;
                    if (cnt_q == 3'h1) begin
                        state_q <= BLS_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Latched request: address changes only in idle (strobes high)
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_addr_out <= '0;
            mem_data_out <= '0;
            lanes_q <= 2'h0;
        end else if (take) begin
            mem_addr_out <= req_addr_in;
            mem_addr_out[BLS_TOP_ADDR_BIT] <=
                req_addr_in[BLS_TOP_ADDR_BIT] & ~half_size_in;
            mem_data_out <= req_wdata_in;
            lanes_q <= req_lanes_in;
        end
    end

    // ------------------------------------------------------------
    // Strobes: chip select and the requested lane selects fall together with write enable on writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chip_select_n_out <= 1'b1;
            upper_byte_n_out <= 1'b1;
            lower_byte_n_out <= 1'b1;
            output_enable_n_out <= 1'b1;
            write_enable_n_out <= 1'b1;
        end else if (take) begin
            chip_select_n_out <= 1'b0;
            upper_byte_n_out <= ~req_lanes_in[1];
            lower_byte_n_out <= ~req_lanes_in[0];
            // Output enable kept high on writes: no contention on the bus
            output_enable_n_out <= req_write_in;
            write_enable_n_out <= ~req_write_in;
        end else if (cnt_q == 3'h1 && state_q != BLS_RECOV) begin
            chip_select_n_out <= 1'b1;
            upper_byte_n_out <= 1'b1;
            lower_byte_n_out <= 1'b1;
            output_enable_n_out <= 1'b1;
            write_enable_n_out <= 1'b1;
        end
    end

    // Drive only the selected lanes, only while writing
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_data_oe_out <= '0;
        end else if (take && req_write_in) begin
            mem_data_oe_out <= lane_bits(req_lanes_in);
        end else if (state_q == BLS_WRITE && cnt_q == 3'h1) begin
            // Freed at the edge where write enable rises; the data hold
            // time then rests on board delay
            mem_data_oe_out <= '0;
        end
    end

    // ------------------------------------------------------------
    // Read capture
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
        end else begin
            rd_valid_out <= (state_q == BLS_READ && cnt_q == 3'h1);
            if (state_q == BLS_READ && cnt_q == 3'h1) begin
                rd_data_out <= mem_data_in & lane_bits(lanes_q);
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Address may only move while the chip is deselected
    a_addr_stable: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !chip_select_n_out && !$past(chip_select_n_out)
        |-> $stable(mem_addr_out))
        else $error("address moved while selected");
    a_wr_pulse_len: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(write_enable_n_out) |-> !write_enable_n_out[*2])
        else $error("write pulse too short");
    a_wr_sel_together: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(write_enable_n_out) |-> $fell(chip_select_n_out))
        else $error("select not with write enable");
    a_no_oe_on_wr: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        !write_enable_n_out |-> output_enable_n_out)
        else $error("output enable during write");
    // A rising select must stay high for a whole recovery cycle
    a_recov_gap: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        $rose(chip_select_n_out) |=> chip_select_n_out)
        else $error("no recovery after access");
    a_half_top: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        half_size_in && $past(half_size_in) && $fell(chip_select_n_out)
        |-> !mem_addr_out[BLS_TOP_ADDR_BIT])
        else $error("top address bit high in half size");
    a_rd_timing: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(output_enable_n_out) |-> ##3 rd_valid_out)
        else $error("read sample not after access time");
    a_oe_lanes: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        |mem_data_oe_out |-> !write_enable_n_out)
        else $error("data driven outside write");
    // Every access keeps the chip selected for at least two clocks
    a_cycle_len: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(chip_select_n_out) |-> !chip_select_n_out[*2])
        else $error("access cycle too short");
    // Address and data stay put through the whole write pulse
    a_wr_hold: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        $fell(write_enable_n_out) |=> ($stable(mem_addr_out)
        && $stable(mem_data_out) && (|mem_data_oe_out)))
        else $error("address or data moved in write pulse");
    // Only the selected lanes are driven, so no fight on the other lane
    a_lane_drive: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        (|mem_data_oe_out) |-> (mem_data_oe_out
        == lane_bits(~{upper_byte_n_out, lower_byte_n_out})))
        else $error("data driven on a deselected lane");
    a_idle_float: assert property (
        @(posedge sys_clk_in) disable iff (rst_in)
        chip_select_n_out |-> (mem_data_oe_out == '0))
        else $error("data driven while deselected");
endmodule

// ===== inc/bls_pkg.sv
// Package for the byte-lane static RAM controller.
// Holds pin widths, timing figures in ns and derived cycle counts at 40 MHz.
package bls_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int BLS_ADDR_W = 14;
    localparam int BLS_DATA_W = 16;
    localparam int BLS_TOP_ADDR_BIT = 13;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int BLS_CLK_PERIOD_NS = 25;
    localparam int READ_CYCLE_MIN_NS = 50;
    localparam int ADDRESS_ACCESS_MAX_NS = 50;
    localparam int OUTPUT_ENABLE_ACCESS_MAX_NS = 30;
    localparam int WRITE_CYCLE_MIN_NS = 50;
    localparam int WRITE_PULSE_MIN_NS = 40;
    localparam int ADDRESS_TO_WRITE_END_MIN_NS = 45;
    localparam int DATA_TO_WRITE_END_MIN_NS = 20;
    localparam int WRITE_RECOVERY_MIN_NS = 5;
    // Least times round up, one cycle at the least
    function automatic int bls_cyc_up(input int ns);
        int c;
        c = (ns + BLS_CLK_PERIOD_NS - 1) / BLS_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    // Read sample waits out the address access time (plus one for margin)
    localparam int READ_WAIT_CYC = bls_cyc_up(ADDRESS_ACCESS_MAX_NS) + 1;
    localparam int WRITE_PULSE_CYC = bls_cyc_up(ADDRESS_TO_WRITE_END_MIN_NS);
    localparam int WRITE_RECOV_CYC = bls_cyc_up(WRITE_RECOVERY_MIN_NS);
    localparam logic [2:0] BLS_RD_WAIT = 3'(READ_WAIT_CYC);
    localparam logic [2:0] BLS_WR_PULSE = 3'(WRITE_PULSE_CYC);
    localparam logic [2:0] BLS_WR_RECOV = 3'(WRITE_RECOV_CYC);
    typedef enum logic [1:0] {BLS_IDLE, BLS_READ, BLS_WRITE, BLS_RECOV}
        bls_state_t;
endpackage

// ===== sim/bls_sram_model.sv
// Pin-level model of the byte-lane static RAM for the controller bench.
// Assumes the bench feeds bus_out back as the controller's data input.
`timescale 1ns/1ps
module bls_sram_model #(
    parameter int ACC_NS = 50
) (
    input wire logic clk_in,
    input wire logic [13:0] addr_in,
    input wire logic cs_n_in,
    input wire logic ub_n_in,
    input wire logic lb_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic half_in,
    input wire logic [15:0] host_d_in,
    input wire logic [15:0] host_oe_in,
    output logic [15:0] bus_out,
    output logic viol_out
);
    logic [15:0] mem [0:16383];
    logic [15:0] last_q = 16'h0000;
    logic [15:0] lane;
    logic [15:0] drv;
    logic [13:0] a_q = 14'h0000;
    logic rdy = 1'b0;
    logic wa_q = 1'b0;
    logic wp_bad = 1'b0;
    realtime t_we = -100.0;
    initial for (int i = 0; i < 16384; i++) mem[i] = 16'h0000;
    // -------------------------------------------------------
    // Pins
    // -------------------------------------------------------
    // Lanes selected only with chip low; both lanes high is standby
    assign lane = {{8{!ub_n_in}}, {8{!lb_n_in}}}
        & {16{!cs_n_in}};
    assign drv = lane
        & {16{!oe_n_in && we_n_in && rdy}};
    // Undriven bits flip every cycle so a stale value never passes
    assign bus_out = (host_oe_in & host_d_in)
        | (~host_oe_in & ((drv & mem[addr_in]) | (~drv & ~last_q)));
    // Data only after the slowest access time, no clock needed
    always @(addr_in, cs_n_in, oe_n_in) begin
        rdy = 1'b0;
        rdy <= #(ACC_NS) 1'b1;
    end
    // Sampled mid-cycle: write overlap stores the selected lanes only
    always @(negedge clk_in) begin
        if (!we_n_in)
            mem[addr_in] <= (mem[addr_in] & ~lane) | (host_d_in & lane);
        last_q <= bus_out;
        wa_q <= !cs_n_in && !we_n_in;
        a_q <= addr_in;
    end
    // Watch of the controller side of the pins
    always @(negedge we_n_in) t_we = $realtime;
    always @(posedge we_n_in) if ($realtime - t_we < 40.0) wp_bad = 1'b1;
    assign viol_out = wp_bad
        | (wa_q && !cs_n_in && !we_n_in && addr_in != a_q)
        | (|(host_oe_in & drv))
        | (half_in && !cs_n_in && addr_in[13]);
endmodule

// ===== sim/tb_bls_ctrl.sv
// Self-checking bench for the byte-lane static RAM controller.
// Assumes bls_pkg and the behavioural RAM model are compiled first.
`timescale 1ns/1ps
module tb_bls_ctrl;
    import bls_pkg::*;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, half_size_in = 1'b0;
    logic req_in = 1'b0, req_write_in = 1'b0, viol, viol_q = 1'b0;
    logic [1:0] req_lanes_in = 2'h0;
    logic [13:0] req_addr_in = 14'h0000, mem_addr_out;
    logic [15:0] req_wdata_in = 16'h0000, rd_data_out, mem_data_in;
    logic [15:0] mem_data_out, mem_data_oe_out;
    logic req_ready_out, rd_valid_out, chip_select_n_out, upper_byte_n_out;
    logic lower_byte_n_out, output_enable_n_out, write_enable_n_out;
    logic [15:0] shadow [0:16383];
    logic [15:0] exp_q [$];
    int num_errors = 0, checks = 0;
    bls_ctrl dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .half_size_in(half_size_in), .req_in(req_in),
        .req_write_in(req_write_in), .req_lanes_in(req_lanes_in),
        .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
        .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
        .rd_data_out(rd_data_out), .mem_addr_out(mem_addr_out),
        .chip_select_n_out(chip_select_n_out),
        .upper_byte_n_out(upper_byte_n_out),
        .lower_byte_n_out(lower_byte_n_out),
        .output_enable_n_out(output_enable_n_out),
        .write_enable_n_out(write_enable_n_out),
        .mem_data_in(mem_data_in), .mem_data_out(mem_data_out),
        .mem_data_oe_out(mem_data_oe_out));
    bls_sram_model #(.ACC_NS(ADDRESS_ACCESS_MAX_NS)) ram_u (
        .clk_in(sys_clk_in),
        .addr_in(mem_addr_out), .cs_n_in(chip_select_n_out),
        .ub_n_in(upper_byte_n_out), .lb_n_in(lower_byte_n_out),
        .oe_n_in(output_enable_n_out), .we_n_in(write_enable_n_out),
        .half_in(half_size_in), .host_d_in(mem_data_out),
        .host_oe_in(mem_data_oe_out), .bus_out(mem_data_in), .viol_out(viol));
    // -------------------------------------------------------
    // Tasks
    // -------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One request, taken at the first rising edge with ready high
    task automatic op(input logic wr, input logic [1:0] ln,
                      input logic [13:0] a, input logic [15:0] d);
        logic [15:0] m;
        logic [13:0] ea;
        int n;
        // Let an edge pass so req_in is never set twice in one step
        @(negedge sys_clk_in);
        m = {{8{ln[1]}}, {8{ln[0]}}};
        ea = half_size_in ? {1'b0, a[12:0]} : a;
        {req_write_in, req_lanes_in, req_addr_in, req_wdata_in} =
            {wr, ln, a, d};
        req_in = 1'b1;
        for (n = 0; req_ready_out !== 1'b1; n++) begin
            if (n > 20) begin
                num_errors++;
                close_out();
            end
            @(negedge sys_clk_in);
        end
        @(negedge sys_clk_in);
        req_in = 1'b0;
        if (wr) shadow[ea] = (shadow[ea] & ~m) | (d & m);
        else exp_q.push_back(shadow[ea] & m);
    endtask
    // Results come back in order; each takes the oldest note
    always @(negedge sys_clk_in) begin
        viol_q <= viol_q | viol;
        if (rd_valid_out === 1'b1 && exp_q.size() == 0)
            check("rd_valid", 16'h0001, 16'h0000);
        else if (rd_valid_out === 1'b1)
            check("rd_data", rd_data_out, exp_q.pop_front());
    end
    always #12.5 sys_clk_in = ~sys_clk_in;
    // -------------------------------------------------------
    // Sequence
    // -------------------------------------------------------
    initial begin
        for (int i = 0; i < 16384; i++) shadow[i] = 16'h0000;
        void'($urandom(32'hDBF4929C));
        repeat (10) @(negedge sys_clk_in);
        rst_in = 1'b0;
        // Lane writes and lane reads back to back on one word
        for (int ln = 1; ln < 4; ln++) begin
            op(1'b1, 2'(ln), 14'h0005, 16'($urandom));
            for (int r = 1; r < 4; r++) op(1'b0, 2'(r), 14'h0005, 16'h0000);
        end
        // Top address bit picks the other bank unless half size
        op(1'b1, 2'h3, 14'h2005, 16'($urandom));
        op(1'b0, 2'h3, 14'h0005, 16'h0000);
        op(1'b0, 2'h3, 14'h2005, 16'h0000);
        // Let the read end first: the model flags bit 13 in half size
        repeat (5) @(negedge sys_clk_in);
        half_size_in = 1'b1;
        op(1'b1, 2'h3, 14'h2009, 16'($urandom));
        op(1'b0, 2'h3, 14'h0009, 16'h0000);
        half_size_in = 1'b0;
        repeat (40) op(1'($urandom), 2'($urandom_range(1, 3)),
            14'($urandom) & 14'h200F, 16'($urandom));
        // Empty lane mask is ignored and keeps the chip deselected
        repeat (5) @(negedge sys_clk_in);
        {req_in, req_write_in, req_lanes_in} = 4'h8;
        repeat (6) begin
            @(negedge sys_clk_in);
            check("ready", {15'h0000, req_ready_out}, 16'h0001);
            check("cs_n", {15'h0000, chip_select_n_out}, 16'h0001);
        end
        req_in = 1'b0;
        // Second reset in idle: strobes high, data released, memory kept
        rst_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        check("strobes", {11'h000, chip_select_n_out, upper_byte_n_out,
            lower_byte_n_out, output_enable_n_out,
            write_enable_n_out}, 16'h001F);
        check("data_oe", mem_data_oe_out, 16'h0000);
        rst_in = 1'b0;
        op(1'b0, 2'h3, 14'h2005, 16'h0000);
        repeat (8) @(negedge sys_clk_in);
        check("pending", 16'(exp_q.size()), 16'h0000);
        check("pin_rules", 16'(viol_q), 16'h0000);
        close_out();
    end
endmodule
